/* File: pdc_map.svh */
// Offsets, field positions and reset values of the PWM block.
// Assumes inclusion by the design, checker and bench.
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH
// Word byte addresses on the Avalon-MM slave
`define PDC_DUTY1_OFS 8'h00
`define PDC_DUTY2_OFS 8'h04
`define PDC_DUTY3_OFS 8'h08
`define PDC_DUTY4_OFS 8'h0C
`define PDC_TBCTRL_OFS 8'h10
`define PDC_OUTCTRL_OFS 8'h14
`define PDC_UPDCTRL_OFS 8'h18
`define PDC_DTVAL_OFS 8'h1C
`define PDC_DTSEL_OFS 8'h20
`define PDC_STATUS_OFS 8'h24
// Time base control fields
`define PDC_TB_RUN_BIT 0
`define PDC_TB_MODE_LSB 1
// Update control fields
`define PDC_UPD_BLOCK_BIT 0
`define PDC_UPD_IMM_BIT 1
// Dead-time value fields: A value [5:0], A prescale [7:6], B [13:8], [15:14]
`define PDC_DTA_LSB 0
`define PDC_DEADTIME_A_PRESCALE_LSB 6
`define PDC_DTB_LSB 8
`define PDC_DEADTIME_B_PRESCALE_LSB 14
// Reset values
`define PDC_DUTY_RST 16'h0000
`define PDC_CTRL_RST 16'h0000
`define PDC_UNMAPPED_RD 32'h0000_0000
`endif

/* File: pdc_pkg.sv */
// Types shared by the PWM duty-compare and dead-time block.
// Assumes the map header sits in the same folder.
package pdc_pkg;
    // Time base modes
    typedef enum logic [1:0] {
        PDC_FREE_RUN = 2'h0,
        PDC_SINGLE_SHOT = 2'h1,
        PDC_UP_DOWN = 2'h2,
        PDC_UP_DOWN_DBL = 2'h3
    } pdc_mode_t;
    // Dead-time generator states, one-hot
    typedef enum logic [2:0] {
        PDC_DT_IDLE = 3'b001,
        PDC_DT_COUNT = 3'b010,
        PDC_DT_DONE = 3'b100
    } pdc_dt_state_t;
    // Timer view handed in by the period timer
    typedef struct packed {
        logic [14:0] count;
        logic countDown;
        logic [14:0] period;
        logic atZero;
        logic periodMatch;
    } pdc_timer_t;
    // One output pair
    typedef struct packed {
        logic high;
        logic low;
    } pdc_pair_t;
endpackage

/* File: pdc_pwm_duty_deadtime.sv */
// Four-channel duty compare, double-buffered duties and dead-time insertion.
// Assumes a period timer on sys_clk
// and an Avalon-MM master on the same clock.
`timescale 1ns/100ps
`include "pdc_map.svh"

// Functional notes
// RULE1: Edge mode: on at zero, off at match
// RULE2: Edge: zero never on, above period always
// RULE3: Up/down: down match on, up match off
// RULE4: Center: zero never on, equal period always
// RULE5: Four 16-bit duty registers, one each
// RULE6: Duty LSB picks early or late edge
// RULE7: Buffer plus separate active compare register
// RULE8: Edge mode loads at period match reset
// RULE9: Run off copies buffers; edge needs unblocked
// RULE10: Up/down loads at zero counting up
// RULE11: Double update loads at zero and period
// RULE12: Immediate enable applies writes at once
// RULE13: Immediate write shortens, lengthens or starts pulse; the start test compares the old active value, not the new one
// RULE14: Generator n drives pair n, low complemented
// RULE15: Independent bit clear selects complementary; reset
// RULE16: Optional dead interval holds both outputs off
// RULE17: Two dead-time values, edge or pair use
// RULE18: Per pair active and inactive edge selects
// RULE19: Six-bit down counter fed by edge detectors
// RULE20: Per value prescale of 1,2,4,8 cycles
// RULE21: Prescalers clear on load, config write, reset
// RULE22: Software keeps dead-time config while running
// RULE23: Mode field: free, single, updown, double
// RULE24: Update block stops buffered transfers
// RULE25: Edge loads count; activating output held off
module pdc_pwm_duty_deadtime import pdc_pkg::*; #(
    parameter int NUM_CH = 4,
    parameter int DUTY_W = 16,
    parameter int DT_W = 6
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pdc_timer_t timerIn,
    output logic timebaseRun,
    output logic [1:0] timebaseModeSel,
    output logic [NUM_CH-1:0] pairHighOut,
    output logic [NUM_CH-1:0] pairLowOut
);
    logic [DUTY_W-1:0] dutyBuf_r [NUM_CH];
    logic [DUTY_W-1:0] dutyAct_r [NUM_CH];
    logic [15:0] tbCtrl_r;
    logic [15:0] outCtrl_r;
    logic [15:0] updCtrl_r;
    logic [15:0] dtVal_r;
    logic [15:0] dtSel_r;
    logic ack_r;
    logic [31:0] rdData_r;
    logic [NUM_CH-1:0] cmpOut_r;
    logic [NUM_CH-1:0] cmpPrev_r;
    logic [NUM_CH-1:0] dutyWr;
    logic [NUM_CH-1:0] dtLoad;
    logic [2:0] presA_r;
    logic [2:0] presB_r;
    logic tickA;
    logic tickB;
    logic dtCfgWr;
    logic runBit;
    logic updBlock;
    logic immUpd;
    logic edgeMode;
    logic loadEvent;
    logic [15:0] wrData16;

    // One wait state: request is answered the cycle after it is seen
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // Byte lanes merge into the low half; upper half has no storage
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Writes are taken at the edge that ends the wait
    logic wrStrobe;
    assign wrStrobe = avs_write & ack_r;
    assign wrData16 = avs_writedata[15:0];
    assign dtCfgWr = wrStrobe & ((avs_address == `PDC_DTVAL_OFS) |
                                 (avs_address == `PDC_DTSEL_OFS));

    // Control registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tbCtrl_r <= `PDC_CTRL_RST;
            outCtrl_r <= `PDC_CTRL_RST;
            updCtrl_r <= `PDC_CTRL_RST;
            dtVal_r <= `PDC_CTRL_RST;
            dtSel_r <= `PDC_CTRL_RST;
        end else if (wrStrobe) begin
            case (avs_address)
                `PDC_TBCTRL_OFS: tbCtrl_r <= merge16(tbCtrl_r, avs_writedata,
                                                     avs_byteenable);
                `PDC_OUTCTRL_OFS: outCtrl_r <= merge16(outCtrl_r,
                                             avs_writedata, avs_byteenable);
                `PDC_UPDCTRL_OFS: updCtrl_r <= merge16(updCtrl_r,
                                             avs_writedata, avs_byteenable);
                `PDC_DTVAL_OFS: dtVal_r <= merge16(dtVal_r, avs_writedata,
                                                   avs_byteenable);
                `PDC_DTSEL_OFS: dtSel_r <= merge16(dtSel_r, avs_writedata,
                                                   avs_byteenable);
                default: ;
            endcase
        end
    end

    // RULE23: mode field decode
    assign runBit = tbCtrl_r[`PDC_TB_RUN_BIT];
    assign timebaseRun = runBit;
    assign timebaseModeSel = tbCtrl_r[`PDC_TB_MODE_LSB +: 2];
    assign edgeMode = (timebaseModeSel == PDC_FREE_RUN) |
                      (timebaseModeSel == PDC_SINGLE_SHOT);
    assign updBlock = updCtrl_r[`PDC_UPD_BLOCK_BIT];
    assign immUpd = updCtrl_r[`PDC_UPD_IMM_BIT];

    // Period-boundary load point per mode
    always_comb begin
        case (timebaseModeSel)
            // RULE8: edge load at match
            PDC_FREE_RUN, PDC_SINGLE_SHOT: loadEvent = timerIn.periodMatch;
            // RULE10: zero, counting up
            PDC_UP_DOWN: loadEvent = timerIn.atZero;
            // RULE11: zero and period
            PDC_UP_DOWN_DBL: loadEvent = timerIn.atZero |
                                         timerIn.periodMatch;
            default: loadEvent = 1'b0;
        endcase
    end

    // Read data registered, so it stands at the edge waitrequest drops
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdData_r <= `PDC_UNMAPPED_RD;
        end else begin
            case (avs_address)
                `PDC_DUTY1_OFS: rdData_r <= {16'h0000, dutyBuf_r[0]};
                `PDC_DUTY2_OFS: rdData_r <= {16'h0000, dutyBuf_r[1]};
                `PDC_DUTY3_OFS: rdData_r <= {16'h0000, dutyBuf_r[2]};
                `PDC_DUTY4_OFS: rdData_r <= {16'h0000, dutyBuf_r[3]};
                `PDC_TBCTRL_OFS: rdData_r <= {16'h0000, tbCtrl_r};
                `PDC_OUTCTRL_OFS: rdData_r <= {16'h0000, outCtrl_r};
                `PDC_UPDCTRL_OFS: rdData_r <= {16'h0000, updCtrl_r};
                `PDC_DTVAL_OFS: rdData_r <= {16'h0000, dtVal_r};
                `PDC_DTSEL_OFS: rdData_r <= {16'h0000, dtSel_r};
                `PDC_STATUS_OFS: rdData_r <= {24'h00_0000, pairLowOut,
                                              pairHighOut};
                default: rdData_r <= `PDC_UNMAPPED_RD;
            endcase
        end
    end
    assign avs_readdata = rdData_r;

    // RULE22: config assumed stable while running
    // Dead-time prescalers; a tick every 1,2,4 or 8 cycles
    logic [NUM_CH-1:0] anyLoad;
    assign anyLoad = dtLoad;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            presA_r <= 3'h0;
            presB_r <= 3'h0;
        end else if (dtCfgWr || (|anyLoad)) begin
            // RULE21: prescaler clear events
            presA_r <= 3'h0;
            presB_r <= 3'h0;
        end else begin
            presA_r <= presA_r + 3'h1;
            presB_r <= presB_r + 3'h1;
        end
    end

    // RULE20: prescale select 1/2/4/8
    function automatic logic presTick(input logic [2:0] cnt,
                                      input logic [1:0] sel);
        logic [2:0] mask;
        mask = 3'((4'h1 << sel) - 4'h1);
        return (cnt & mask) == mask;
    endfunction
    assign tickA = presTick(presA_r, dtVal_r[`PDC_DEADTIME_A_PRESCALE_LSB +: 2]);
    assign tickB = presTick(presB_r, dtVal_r[`PDC_DEADTIME_B_PRESCALE_LSB +: 2]);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh
            logic [DUTY_W-1:0] act;
            logic [15:0] dutyHalf;
            logic late;
            logic matchNow;
            logic matchLate_r;
            logic cmpNxt;
            logic [DT_W-1:0] dtCnt_r;
            logic [DT_W-1:0] dtLoadVal;
            logic dtTick;
            logic dead;
            pdc_dt_state_t dtState_r;

            // RULE5: one 16-bit duty register per generator
            assign dutyWr[g] = wrStrobe &&
                (avs_address == 8'(g * 4));

            // RULE7: buffer written by software
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    dutyBuf_r[g] <= `PDC_DUTY_RST;
                end else if (dutyWr[g]) begin
                    dutyBuf_r[g] <= merge16(dutyBuf_r[g], avs_writedata,
                                            avs_byteenable);
                end
            end

            // Active compare register transfer
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    dutyAct_r[g] <= `PDC_DUTY_RST;
                end else if (immUpd && dutyWr[g]) begin
                    // RULE12: immediate update
                    dutyAct_r[g] <= merge16(dutyBuf_r[g], avs_writedata,
                                            avs_byteenable);
                end else if (!runBit && !(edgeMode && updBlock)) begin
                    // RULE9: continuous copy while stopped
                    dutyAct_r[g] <= dutyBuf_r[g];
                end else if (runBit && loadEvent && !updBlock) begin
                    // RULE24: block stops period loads
                    dutyAct_r[g] <= dutyBuf_r[g];
                end
            end

            // RULE6: duty holds half counts; LSB delays edge half a count
            assign act = dutyAct_r[g];
            assign dutyHalf = {1'b0, act[15:1]};
            assign late = act[0];
            assign matchNow = (dutyHalf == {1'b0, timerIn.count});

            // Compare next state; RULE13 falls out of comparing live value
            always_comb begin
                cmpNxt = cmpOut_r[g];
                if (edgeMode) begin
                    // RULE2: zero off, above period on
                    if (act == 16'h0000) begin
                        cmpNxt = 1'b0;
                    end else if (dutyHalf > {1'b0, timerIn.period}) begin
                        cmpNxt = 1'b1;
                    end else if (matchNow && !late) begin
                        cmpNxt = 1'b0;
                    // RULE1: on at count zero
                    end else if (timerIn.count == 15'h0000) begin
                        cmpNxt = 1'b1;
                    end else if (matchLate_r) begin
                        cmpNxt = 1'b0;
                    // RULE13: inactive, pre-write active value above count
                    end else if (dutyHalf > {1'b0, timerIn.count} &&
                                 immUpd && dutyWr[g]) begin
                        cmpNxt = 1'b1;
                    end
                end else begin
                    // RULE4: zero off, equal period on
                    if (act == 16'h0000) begin
                        cmpNxt = 1'b0;
                    end else if (dutyHalf == {1'b0, timerIn.period}) begin
                        cmpNxt = 1'b1;
                    // RULE3: direction decides match action
                    end else if (matchNow) begin
                        cmpNxt = timerIn.countDown;
                    end
                end
            end

            // Compare output and the half-count late edge
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    cmpOut_r[g] <= 1'b0;
                    cmpPrev_r[g] <= 1'b0;
                    matchLate_r <= 1'b0;
                end else begin
                    cmpOut_r[g] <= cmpNxt;
                    cmpPrev_r[g] <= cmpOut_r[g];
                    matchLate_r <= edgeMode & matchNow & late;
                end
            end

            // RULE19: edge detector loads down counter
            assign dtLoad[g] = cmpOut_r[g] ^ cmpPrev_r[g];
            // RULE18: per-pair edge select; RULE17: value A or B
            always_comb begin
                if ((cmpOut_r[g] ? dtSel_r[2*g] : dtSel_r[2*g+1]) == 1'b0)
                begin
                    dtLoadVal = dtVal_r[`PDC_DTA_LSB +: DT_W];
                    dtTick = tickA;
                end else begin
                    dtLoadVal = dtVal_r[`PDC_DTB_LSB +: DT_W];
                    dtTick = tickB;
                end
            end

            // RULE25: dead-time counter state machine
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    dtState_r <= PDC_DT_IDLE;
                    dtCnt_r <= '0;
                end else if (dtLoad[g]) begin
                    dtCnt_r <= dtLoadVal;
                    dtState_r <= (dtLoadVal == '0) ? PDC_DT_IDLE
                                                   : PDC_DT_COUNT;
                end else begin
                    case (dtState_r)
                        PDC_DT_IDLE: ;
                        PDC_DT_COUNT: begin
                            if (dtTick) begin
                                dtCnt_r <= dtCnt_r - 1'b1;
                                if (dtCnt_r == 6'(1)) begin
                                    dtState_r <= PDC_DT_DONE;
                                end
                            end
                        end
                        PDC_DT_DONE: begin
                            // Spare cycle
                            dtState_r <= PDC_DT_IDLE;
                        end
                        default: dtState_r <= PDC_DT_IDLE;
                    endcase
                end
            end

            // Load cycle is the first dead one; it masks both the rising and the falling side
            assign dead = dtLoad[g] ? (dtLoadVal != '0) :
                (dtState_r == PDC_DT_COUNT) & ~(dtCnt_r == 6'(1) & dtTick);

            // RULE14: pair n from generator n, low complemented
            // RULE15: independent bit clear gives complementary
            // RULE16: dead interval holds both off
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    pairHighOut[g] <= 1'b0;
                    pairLowOut[g] <= 1'b0;
                end else if (outCtrl_r[g]) begin
                    pairHighOut[g] <= cmpOut_r[g];
                    pairLowOut[g] <= cmpOut_r[g];
                end else begin
                    // Same lag as the compare
                    pairHighOut[g] <= cmpOut_r[g] & ~dead;
                    pairLowOut[g] <= ~cmpOut_r[g] & ~dead;
                end
            end
        end
    endgenerate
endmodule

/* File: pdc_pwm_chk.sv */
// Port checker of the PWM block.
// Assumes one clock, sync active-low reset, no independent pairs in use.
`timescale 1ns/100ps
`include "pdc_map.svh"
module pdc_pwm_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timebaseRun,
    input wire logic [1:0] timebaseModeSel,
    input wire logic [NUM_CH-1:0] pairHighOut,
    input wire logic [NUM_CH-1:0] pairLowOut
);
    logic [31:0] wdQ;
    // Write data one cycle back
    always_ff @(posedge sys_clk) begin
        wdQ <= avs_writedata;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_waitFirst;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_waitFirst: assert property (p_waitFirst)
        else $error("no first wait");
    property p_waitOne;
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_waitOne: assert property (p_waitOne)
        else $error("wait too long");
    property p_idleNoWait;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    a_idleNoWait: assert property (p_idleNoWait)
        else $error("idle wait");
    property p_rdUpper;
        avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    a_rdUpper: assert property (p_rdUpper)
        else $error("upper bits set");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 8'h28
            |-> avs_readdata == `PDC_UNMAPPED_RD;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped nonzero");
    property p_runBit;
        avs_write && !avs_waitrequest && avs_address == `PDC_TBCTRL_OFS
            |=> timebaseRun == wdQ[0] && timebaseModeSel == wdQ[2:1];
    endproperty
    a_runBit: assert property (p_runBit)
        else $error("ctrl not mirrored");
    property p_noShoot;
        (pairHighOut & pairLowOut) == '0;
    endproperty
    a_noShoot: assert property (p_noShoot)
        else $error("pair shoots through");
    property p_resetOut;
        @(posedge sys_clk) disable iff (1'b0)
        !resetn |=> pairHighOut == '0 && pairLowOut == '0 && !timebaseRun;
    endproperty
    a_resetOut: assert property (p_resetOut)
        else $error("not idle at reset");
endmodule
bind pdc_pwm_duty_deadtime pdc_pwm_chk #(.NUM_CH(NUM_CH)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timebaseRun(timebaseRun),
    .timebaseModeSel(timebaseModeSel), .pairHighOut(pairHighOut),
    .pairLowOut(pairLowOut));

/* File: pdc_bridge_model.sv */
// Half-bridge stand-in driven by the four output pairs.
// Assumes outputs active high on the bench clock.
`timescale 1ns/100ps
module pdc_bridge_model (
    input wire logic sys_clk,
    input wire logic [3:0] pairHighOut,
    input wire logic [3:0] pairLowOut,
    output logic [3:0] phaseNode,
    output int shootCount
);
    initial shootCount = 0;
    initial phaseNode = 4'h0;
    // Node follows the closed switch; an open pair toggles the node each cycle
    always @(posedge sys_clk) begin
        for (int c = 0; c < 4; c++) begin
            if (pairHighOut[c] === 1'b1 && pairLowOut[c] === 1'b1) begin
                shootCount++;
            end else if (pairHighOut[c] === 1'b1) begin
                phaseNode[c] <= 1'b1;
            end else if (pairLowOut[c] === 1'b1) begin
                phaseNode[c] <= 1'b0;
            end else begin
                phaseNode[c] <= ~phaseNode[c];
            end
        end
    end
endmodule

/* File: tb_pwm_duty_compare_deadtime.sv */
// Testbench for the PWM duty-compare and dead-time block.
// Assumes design, package, map header and bridge model alongside.
`timescale 1ns/100ps
`include "pdc_map.svh"
module tb_pwm_duty_compare_deadtime import pdc_pkg::*; ;
    localparam int P = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pdc_timer_t timerIn;
    logic timebaseRun;
    logic [1:0] timebaseModeSel;
    logic [3:0] pairHighOut;
    logic [3:0] pairLowOut;
    logic [14:0] tCnt = 15'h0000;
    logic tDn = 1'b0;
    int shootCount;
    int err_count = 0;
    int n_compared = 0;
    // 40 MHz clock
    initial forever #12.5 sys_clk = ~sys_clk;
    // Period timer stand-in: edge modes wrap at P, up/down turn at P
    always @(posedge sys_clk) begin
        if (!resetn) begin
            tCnt <= 15'h0000;
            tDn <= 1'b0;
        end else if (timebaseRun === 1'b1) begin
            tDn <= timebaseModeSel[1] & (tDn ? tCnt != 1 : tCnt == P);
            tCnt <= (tDn || timebaseModeSel[1] && tCnt == P) ?
                tCnt - 15'h0001 : (tCnt == P) ? 15'h0000 : tCnt + 15'h0001;
        end
    end
    assign timerIn = '{count: tCnt, countDown: tDn, period: 15'(P),
        atZero: tCnt == 15'h0000, periodMatch: tCnt == 15'(P)};
    pdc_pwm_duty_deadtime u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timerIn(timerIn),
        .timebaseRun(timebaseRun), .timebaseModeSel(timebaseModeSel),
        .pairHighOut(pairHighOut), .pairLowOut(pairLowOut));
    pdc_bridge_model u_bridge (.sys_clk(sys_clk), .pairHighOut(pairHighOut),
        .pairLowOut(pairLowOut), .phaseNode(), .shootCount(shootCount));
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One transfer; junk on upper lanes must be dropped
    task automatic bus_cyc(input logic wr, input logic [7:0] a,
        input logic [15:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'($urandom), d};
        avs_byteenable <= {2'($urandom), 2'b11};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) err_count++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus_cyc(1'b1, a, d, q);
    endtask
    task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        bus_cyc(1'b0, a, 16'h0000, q);
        chk_reg(nm, e, q);
    endtask
    task automatic chk_cnt(string nm, int e, int g);
        n_compared++;
        if (g != e) begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Active cycles per period
    function automatic int exp_hi(logic [1:0] m, logic [15:0] d);
        int k;
        k = int'(d[15:1]);
        if (m[1]) return (k >= P) ? 2 * P : 2 * k;
        return (k > P) ? P + 1 : k + int'(d[0]);
    endfunction
    // Whole-period counts ignore start phase
    task automatic check_pairs(logic [1:0] m, logic [15:0] du[4],
        int dr[4], int df[4]);
        int hi[4] = '{0, 0, 0, 0};
        int lo[4] = '{0, 0, 0, 0};
        int w;
        int len;
        len = m[1] ? 2 * P : P + 1;
        repeat (2 * len) @(posedge sys_clk);
        repeat (len) begin
            @(posedge sys_clk);
            for (int c = 0; c < 4; c++) begin
                hi[c] += int'(pairHighOut[c] === 1'b1);
                lo[c] += int'(pairLowOut[c] === 1'b1);
            end
        end
        for (int c = 0; c < 4; c++) begin
            w = exp_hi(m, du[c]);
            if (w == 0 || w == len) begin
                chk_cnt("high count", w, hi[c]);
                chk_cnt("low count", len - w, lo[c]);
            end else begin
                chk_cnt("high count", w - dr[c], hi[c]);
                chk_cnt("low count", len - w - df[c], lo[c]);
            end
        end
    endtask
    initial begin
        logic [15:0] du[4];
        int z[4] = '{0, 0, 0, 0};
        int dr[4];
        int df[4];
        logic [1:0] m;
        logic [7:0] sel;
        void'($urandom(32'h9376_1bf8));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            rd_chk("duty reset", 8'(4 * c), {16'h0000, `PDC_DUTY_RST});
        end
        rd_chk("pair mode", `PDC_OUTCTRL_OFS, 32'h0000_0000);
        wr(8'h28, 16'hffff);
        rd_chk("unmapped", 8'h28, `PDC_UNMAPPED_RD);
        // Every mode with zero, full and random duties; odd duty in the edge modes only
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(`PDC_TBCTRL_OFS, {13'h0000, m, 1'b0});
            du[0] = m[1] ? 16'(2 * ($urandom % (P + 1)))
                         : 16'($urandom % (2 * P + 4));
            du[1] = 16'h0000;
            du[2] = m[1] ? 16'(2 * P) : 16'(2 * P + 2);
            du[3] = m[1] ? 16'(2 * ($urandom % P)) : 16'h000b;
            for (int c = 0; c < 4; c++) wr(8'(4 * c), du[c]);
            rd_chk("duty", 8'h0c, {16'h0000, du[3]});
            wr(`PDC_TBCTRL_OFS, {13'h0000, m, 1'b1});
            @(negedge sys_clk);
            chk_reg("mode", 32'({m, 1'b1}), 32'({timebaseModeSel, timebaseRun}));
            check_pairs(m, du, z, z);
            du[0] = 16'(2 * ($urandom % P));
            wr(8'h00, du[0]);
            check_pairs(m, du, z, z);
        end
        // Blocked update, then immediate update
        wr(`PDC_TBCTRL_OFS, 16'h0001);
        wr(`PDC_UPDCTRL_OFS, 16'h0001);
        wr(8'h00, 16'h0014);
        check_pairs(2'b00, du, z, z);
        wr(`PDC_UPDCTRL_OFS, 16'h0003);
        du[0] = 16'h0021;
        wr(8'h00, du[0]);
        check_pairs(2'b00, du, z, z);
        wr(`PDC_UPDCTRL_OFS, 16'h0000);
        // Dead time: each prescale, random selects
        for (int ps = 0; ps < 4; ps++) begin
            wr(`PDC_TBCTRL_OFS, 16'h0000);
            sel = 8'($urandom);
            wr(`PDC_DTVAL_OFS, {2'(3 - ps), 6'h01, 2'(ps), 6'h01});
            wr(`PDC_DTSEL_OFS, {8'h00, sel});
            for (int c = 0; c < 4; c++) begin
                du[c] = 16'h0014;
                wr(8'(4 * c), du[c]);
                dr[c] = sel[2 * c] ? 1 << (3 - ps) : 1 << ps;
                df[c] = sel[2 * c + 1] ? 1 << (3 - ps) : 1 << ps;
            end
            wr(`PDC_TBCTRL_OFS, 16'h0001);
            check_pairs(2'b00, du, dr, df);
        end
        chk_cnt("shoot through", 0, shootCount);
        print_verdict;
    end
    // Hang guard, far past the roughly 1400 cycles needed
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        $display("watchdog expired");
        print_verdict;
    end
endmodule
